// File: hdl/sfq_flash.sv
// multi-lane serial flash core: command sequencer, array, page program engine
`timescale 1ns/10ps
module sfq_flash #(
	parameter int MEM_AW = 20,
	parameter int PROG_CYCLES = sfq_pkg::PROG_CYCLES
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_sck,
	input wire logic [3:0] i_serial_io,
	output logic [3:0] o_serial_io,
	output logic [3:0] o_serial_io_oe_n,
	input wire logic i_quad_enable_bit,
	input wire logic i_protect_complement_bit,
	input wire logic i_sector_granularity_bit,
	input wire logic i_top_bottom_bit,
	input wire logic i_block_protect_2,
	input wire logic i_block_protect_1,
	input wire logic i_block_protect_0,
	output logic o_busy,
	output logic o_write_enable_latch,
	output logic o_wrap_disable_bit,
	output logic [1:0] o_wrap_length_field,
	output logic o_prog_discarded
);
	localparam int PB = sfq_pkg::PAGE_BYTES;
	localparam int PCW = $clog2(PROG_CYCLES + 1);

	typedef struct packed {
		sfq_pkg::sfq_state_t st;
		logic sck_d;
		logic cs_d;
		logic [7:0] op;
		logic [2:0] lanes;
		logic [23:0] sh;
		logic [5:0] nbits;
		logic [3:0] nclk;
		logic [23:0] addr;
		logic wrap_on;
		logic [7:0] ob;
		logic [3:0] orem;
		logic [23:0] paddr;
		logic [7:0] col;
		logic [PB-1:0] mask;
		logic prog_any;
		logic busy;
		logic [PCW-1:0] pcnt;
		logic [8:0] cidx;
		logic write_enable_latch;
		logic wrap_dis;
		logic [1:0] wrap_len;
		logic discarded;
		logic [3:0] io_o;
		logic [3:0] io_oe_n;
	} sfq_core_st_t;

	sfq_core_st_t r, n;

	// array contents are not reset; program before reading back
	logic [7:0] mem [0:(2**MEM_AW)-1];
	logic [7:0] pbuf [0:PB-1];

	logic pb_we;
	logic [7:0] pb_idx;
	logic [7:0] pb_dat;
	logic cm_we;
	logic [MEM_AW-1:0] cm_addr;
	logic [7:0] mem_rd;
	logic [7:0] stat_byte;

	sfq_if #(.AW(MEM_AW)) lnk ();

	sfq_sync u_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_cs_n(i_cs_n),
		.i_sck(i_sck),
		.i_serial_io(i_serial_io),
		.bus(lnk.sync)
	);

	sfq_prot #(.AW(MEM_AW)) u_prot (
		.bus(lnk.prot)
	);

	assign lnk.prot_addr = r.paddr[MEM_AW-1:0];
	assign lnk.bp = {i_block_protect_2, i_block_protect_1, i_block_protect_0};
	assign lnk.tb = i_top_bottom_bit;
	assign lnk.sec = i_sector_granularity_bit;
	assign lnk.cmp = i_protect_complement_bit;
	assign mem_rd = mem[r.addr[MEM_AW-1:0]];

	always_comb begin
		stat_byte = 8'h00;
		stat_byte[sfq_pkg::STAT_BUSY] = r.busy;
		stat_byte[sfq_pkg::STAT_WEL] = r.write_enable_latch;
		stat_byte[sfq_pkg::STAT_BP_LSB +: 3] = lnk.bp;
		stat_byte[sfq_pkg::STAT_TB] = i_top_bottom_bit;
		stat_byte[sfq_pkg::STAT_SEC] = i_sector_granularity_bit;
	end

	// single lane listens on lane 0; wider modes take lanes from 0 upward
	function automatic logic [3:0] lane_in(input logic [2:0] l, input logic [3:0] io);
		logic [3:0] v;
		v = io;
		if (l == sfq_pkg::LANE_1) begin
			v = {3'h0, io[0]};
		end else if (l == sfq_pkg::LANE_2) begin
			v = {2'h0, io[1:0]};
		end
		return v;
	endfunction

	always_comb begin
		logic rise;
		logic fall;
		logic csr;
		logic [3:0] din;
		logic [23:0] shn;
		logic [5:0] nb;
		logic [7:0] byt;
		logic [7:0] ob_src;
		logic [23:0] wmask;
		logic [3:0] dcnt;
		n = r;
		rise = lnk.sck & ~r.sck_d;
		fall = ~lnk.sck & r.sck_d;
		csr = lnk.cs_n & ~r.cs_d;
		din = lane_in(r.lanes, lnk.io);
		shn = (r.sh << r.lanes) | {20'h0, din};
		nb = r.nbits + {3'h0, r.lanes};
		byt = shn[7:0];
		ob_src = r.ob;
		if (r.orem == 4'h0) begin
			ob_src = (r.st == sfq_pkg::ST_STAT) ? stat_byte : mem_rd;
		end
		wmask = (24'(sfq_pkg::WRAP_MIN_BYTES) << r.wrap_len) - 24'h1;
		dcnt = (r.op == sfq_pkg::OP_QUAD_IO) ? 4'(sfq_pkg::QIO_DUMMY_CLKS) :
			4'(sfq_pkg::OUT_DUMMY_CLKS);
		pb_we = 1'b0;
		pb_idx = r.col;
		pb_dat = byt;
		cm_we = 1'b0;
		cm_addr = MEM_AW'({r.paddr[23:8], r.cidx[7:0]});
		n.sck_d = lnk.sck;
		n.cs_d = lnk.cs_n;

		// self-timed program: copy buffered bytes, then hold busy out to the full time
		if (r.busy) begin
			n.pcnt = r.pcnt + PCW'(1); // RULE_21
			if (r.cidx < 9'(PB)) begin
				cm_we = r.mask[r.cidx[7:0]]; // RULE_19
				n.cidx = r.cidx + 9'h1;
			end
			if (r.pcnt == PCW'(PROG_CYCLES - 1)) begin
				n.busy = 1'b0; // RULE_21
				n.write_enable_latch = 1'b0; // RULE_22
			end
		end

		if (lnk.cs_n) begin
			if (csr && r.st == sfq_pkg::ST_PROG) begin
				if (r.nbits == 6'h0 && r.prog_any && !lnk.prot_hit) begin // RULE_20 RULE_23
					n.busy = 1'b1;
					n.pcnt = '0;
					n.cidx = 9'h0;
					n.discarded = 1'b0;
				end else begin
					n.discarded = 1'b1;
				end
			end
			if (csr && r.st == sfq_pkg::ST_HOLD) begin
				n.write_enable_latch = (r.op == sfq_pkg::OP_WREN);
			end
			n.st = sfq_pkg::ST_CMD;
			n.nbits = 6'h0;
			n.nclk = 4'h0;
			n.orem = 4'h0;
			n.lanes = sfq_pkg::LANE_1;
			n.io_oe_n = sfq_pkg::OE_OFF;
		end else if (rise) begin
			n.sh = shn; // RULE_24
			n.nbits = nb;
			unique case (r.st)
				sfq_pkg::ST_CMD: begin
					if (nb == 6'(sfq_pkg::BYTE_BITS)) begin
						n.op = byt;
						n.nbits = 6'h0;
						n.st = sfq_pkg::ST_IGNORE;
						// while busy only the status read is heard
						if (!r.busy || byt == sfq_pkg::OP_RD_STAT) begin
							case (byt)
								sfq_pkg::OP_DUAL_OUT: begin
									n.st = sfq_pkg::ST_ADDR;
								end
								sfq_pkg::OP_QUAD_OUT: begin
									if (i_quad_enable_bit) begin // RULE_04
										n.st = sfq_pkg::ST_ADDR;
									end
								end
								sfq_pkg::OP_DUAL_IO: begin
									n.st = sfq_pkg::ST_ADDR;
									n.lanes = sfq_pkg::LANE_2; // RULE_06
								end
								sfq_pkg::OP_QUAD_IO: begin
									if (i_quad_enable_bit) begin // RULE_09
										n.st = sfq_pkg::ST_ADDR;
										n.lanes = sfq_pkg::LANE_4; // RULE_08
									end
								end
								sfq_pkg::OP_SET_WRAP: begin
									n.st = sfq_pkg::ST_WRAP_DUMMY;
									n.lanes = sfq_pkg::LANE_4; // RULE_11
								end
								sfq_pkg::OP_PAGE_PROG: begin
									if (r.write_enable_latch) begin // RULE_16
										n.st = sfq_pkg::ST_ADDR;
									end
								end
								sfq_pkg::OP_WREN, sfq_pkg::OP_WRDI: begin
									n.st = sfq_pkg::ST_HOLD;
								end
								sfq_pkg::OP_RD_STAT: begin
									n.st = sfq_pkg::ST_STAT; // RULE_21
								end
								default: begin
									n.st = sfq_pkg::ST_IGNORE;
								end
							endcase
						end
					end
				end
				sfq_pkg::ST_ADDR: begin
					if (nb == 6'(sfq_pkg::ADDR_BITS)) begin
						n.nbits = 6'h0;
						n.addr = shn;
						n.paddr = shn;
						n.col = shn[7:0];
						n.mask = '0;
						n.prog_any = 1'b0;
						// wrap is latched per read so a later setting cannot bend a burst
						n.wrap_on = (r.op == sfq_pkg::OP_QUAD_IO) && !r.wrap_dis; // RULE_14
						if (r.op == sfq_pkg::OP_PAGE_PROG) begin
							n.st = sfq_pkg::ST_PROG; // RULE_17
						end else if (r.op == sfq_pkg::OP_DUAL_IO || r.op == sfq_pkg::OP_QUAD_IO) begin
							n.st = sfq_pkg::ST_MODE;
						end else begin
							n.st = sfq_pkg::ST_DUMMY; // RULE_02 RULE_05
							n.nclk = 4'h0;
							n.lanes = (r.op == sfq_pkg::OP_DUAL_OUT) ? sfq_pkg::LANE_2 :
								sfq_pkg::LANE_4;
						end
					end
				end
				sfq_pkg::ST_MODE: begin
					// mode value is not decoded; continuous-read modes are not offered
					if (nb == 6'(sfq_pkg::MODE_BITS)) begin // RULE_07
						n.nbits = 6'h0;
						n.nclk = 4'h0;
						n.st = (r.op == sfq_pkg::OP_QUAD_IO) ? sfq_pkg::ST_DUMMY :
							sfq_pkg::ST_OUT;
					end
				end
				sfq_pkg::ST_DUMMY: begin
					n.nclk = r.nclk + 4'h1;
					if (r.nclk + 4'h1 == dcnt) begin // RULE_02 RULE_05 RULE_08
						n.st = sfq_pkg::ST_OUT;
						n.orem = 4'h0;
					end
				end
				sfq_pkg::ST_PROG: begin
					if (nb == 6'(sfq_pkg::BYTE_BITS)) begin
						pb_we = 1'b1;
						n.mask = r.mask | (PB'(1) << r.col); // RULE_19
						n.col = r.col + 8'h1; // RULE_18
						n.prog_any = 1'b1;
						n.nbits = 6'h0;
					end
				end
				sfq_pkg::ST_WRAP_DUMMY: begin
					if (nb == 6'(sfq_pkg::WRAP_DUMMY_BITS)) begin
						n.nbits = 6'h0;
						n.st = sfq_pkg::ST_WRAP_BITS;
					end
				end
				sfq_pkg::ST_WRAP_BITS: begin
					if (nb == 6'(sfq_pkg::BYTE_BITS)) begin
						n.wrap_dis = byt[sfq_pkg::WRAP_DIS_POS]; // RULE_12 RULE_13
						n.wrap_len = byt[sfq_pkg::WRAP_LEN_LSB +: 2]; // RULE_12 RULE_13
						n.st = sfq_pkg::ST_IGNORE;
					end
				end
				sfq_pkg::ST_HOLD: begin
					// extra clocks after a one-byte command cancel it
					n.st = sfq_pkg::ST_IGNORE;
				end
				sfq_pkg::ST_OUT, sfq_pkg::ST_STAT, sfq_pkg::ST_IGNORE: begin
				end
			endcase
		end else if (fall && (r.st == sfq_pkg::ST_OUT || r.st == sfq_pkg::ST_STAT)) begin
			// output bits change only on falling edges, msb first
			n.ob = ob_src << r.lanes; // RULE_24
			n.orem = ((r.orem == 4'h0) ? 4'(sfq_pkg::BYTE_BITS) : r.orem) - {1'b0, r.lanes};
			if (r.orem == 4'h0 && r.st == sfq_pkg::ST_OUT) begin
				if (r.wrap_on) begin
					n.addr = (r.addr & ~wmask) | ((r.addr + 24'h1) & wmask); // RULE_10
				end else begin
					n.addr = r.addr + 24'h1;
				end
			end
			case (r.lanes)
				sfq_pkg::LANE_4: begin
					n.io_o = ob_src[7:4]; // RULE_04
					n.io_oe_n = sfq_pkg::OE_QUAD; // RULE_03
				end
				sfq_pkg::LANE_2: begin
					n.io_o = {2'h0, ob_src[7:6]}; // RULE_01
					n.io_oe_n = sfq_pkg::OE_DUAL; // RULE_03
				end
				default: begin
					n.io_o = {2'h0, ob_src[7], 1'b0};
					n.io_oe_n = sfq_pkg::OE_SINGLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			r <= '0;
			r.cs_d <= 1'b1;
			r.lanes <= sfq_pkg::LANE_1;
			r.wrap_dis <= sfq_pkg::WRAP_DIS_RST; // RULE_14
			r.io_oe_n <= sfq_pkg::OE_OFF;
		end else begin
			r <= n;
		end
	end

	// array and page buffer carry no reset so they map onto memory
	always_ff @(posedge i_clk_sys) begin
		if (pb_we) begin
			pbuf[pb_idx] <= pb_dat;
		end
		if (cm_we) begin
			mem[cm_addr] <= pbuf[r.cidx[7:0]]; // RULE_23
		end
	end

	assign o_serial_io = r.io_o;
	assign o_serial_io_oe_n = r.io_oe_n;
	assign o_busy = r.busy;
	assign o_write_enable_latch = r.write_enable_latch;
	assign o_wrap_disable_bit = r.wrap_dis;
	assign o_wrap_length_field = r.wrap_len;
	assign o_prog_discarded = r.discarded;
endmodule

// File: hdl/sfq_pkg.sv
// constants and types shared by the multi-lane serial flash block
// Notes on behaviour
// RULE_01: dual output read sends two bits per clock
// RULE_02: dual output read has eight dummy clocks
// RULE_03: host releases data lines before first output
// RULE_04: quad output read needs quad enable, four lanes
// RULE_05: quad output read has eight dummy clocks
// RULE_06: dual io read: address and data on two
// RULE_07: host sends mode byte as all ones
// RULE_08: quad io read: four lanes, four dummies
// RULE_09: quad io read needs quad enable set
// RULE_10: wrapped read loops inside aligned page section
// RULE_11: set wrap: opcode, 24 dummies, eight bits
// RULE_12: only wrap bits six to four matter
// RULE_13: bit four disables wrap, bits six-five length
// RULE_14: wrap setting persists, disable at reset
// RULE_15: host reissues wrap disable after system reset
// RULE_16: page program needs write enable latch set
// RULE_17: host shifts program opcode, address, data serially
// RULE_18: program column wraps inside the page
// RULE_19: partial program leaves other page bytes alone
// RULE_20: select rising off byte boundary discards program
// RULE_21: self-timed program holds busy, status still readable
// RULE_22: program completion clears write enable latch
// RULE_23: protected pages are never programmed
// RULE_24: sample on rising edge, drive on falling
package sfq_pkg;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
	localparam logic [7:0] OP_DUAL_IO = 8'hBB;
	localparam logic [7:0] OP_QUAD_IO = 8'hEB;
	localparam logic [7:0] OP_SET_WRAP = 8'h77;
	localparam logic [7:0] OP_PAGE_PROG = 8'h02;
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_RD_STAT = 8'h05;
	localparam int ADDR_BITS = 24;
	localparam int MODE_BITS = 8;
	localparam int BYTE_BITS = 8;
	localparam int WRAP_DUMMY_BITS = 24;
	localparam int OUT_DUMMY_CLKS = 8;
	localparam int QIO_DUMMY_CLKS = 4;
	localparam int PAGE_BYTES = 256;
	localparam int WRAP_MIN_BYTES = 8;
	localparam int WRAP_DIS_POS = 4;
	localparam int WRAP_LEN_LSB = 5;
	localparam logic WRAP_DIS_RST = 1'b1;
	localparam int STAT_BUSY = 0;
	localparam int STAT_WEL = 1;
	localparam int STAT_BP_LSB = 2;
	localparam int STAT_TB = 5;
	localparam int STAT_SEC = 6;
	localparam int SEC_SHIFT = 12;
	localparam int BLK_SHIFT = 16;
	localparam logic [2:0] BP_NONE = 3'h0;
	localparam logic [2:0] BP_ALL = 3'h7;
	localparam logic [2:0] LANE_1 = 3'h1;
	localparam logic [2:0] LANE_2 = 3'h2;
	localparam logic [2:0] LANE_4 = 3'h4;
	localparam logic [3:0] OE_OFF = 4'hF;
	localparam logic [3:0] OE_QUAD = 4'h0;
	localparam logic [3:0] OE_DUAL = 4'hC;
	localparam logic [3:0] OE_SINGLE = 4'hD;
	localparam logic [5:0] PIN_SYNC_RST = 6'h01;
	localparam int SYS_CLK_NS = 40;
	localparam int TPP_NS = 700000;
	localparam int PROG_CYCLES = (TPP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	typedef enum logic [3:0] {
		ST_CMD,
		ST_ADDR,
		ST_MODE,
		ST_DUMMY,
		ST_OUT,
		ST_STAT,
		ST_PROG,
		ST_WRAP_DUMMY,
		ST_WRAP_BITS,
		ST_HOLD,
		ST_IGNORE
	} sfq_state_t;
endpackage

// File: hdl/sfq_if.sv
// link between the sequencer, its pin synchroniser and its protection decoder
`timescale 1ns/10ps
interface sfq_if #(parameter int AW = 20);
	logic cs_n;
	logic sck;
	logic [3:0] io;
	logic [AW-1:0] prot_addr;
	logic [2:0] bp;
	logic tb;
	logic sec;
	logic cmp;
	logic prot_hit;
	modport sync (output cs_n, sck, io);
	modport prot (input prot_addr, bp, tb, sec, cmp, output prot_hit);
endinterface

// File: hdl/sfq_sync.sv
// two-stage synchronisers for select, serial clock and data lines
`timescale 1ns/10ps
module sfq_sync (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_sck,
	input wire logic [3:0] i_serial_io,
	sfq_if.sync bus
);
	typedef struct packed {
		logic [5:0] meta;
		logic [5:0] stab;
	} sfq_sync_st_t;

	sfq_sync_st_t r, n;

	// meta feeds only stab; every consumer reads the second stage
	always_comb begin
		n.meta = {i_serial_io, i_sck, i_cs_n};
		n.stab = r.meta;
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			r.meta <= sfq_pkg::PIN_SYNC_RST;
			r.stab <= sfq_pkg::PIN_SYNC_RST;
		end else begin
			r <= n;
		end
	end

	assign bus.cs_n = r.stab[0];
	assign bus.sck = r.stab[1];
	assign bus.io = r.stab[5:2];
endmodule

// File: hdl/sfq_prot.sv
// decodes the block-protect bits into a hit for one address
`timescale 1ns/10ps
module sfq_prot #(parameter int AW = 20) (
	sfq_if.prot bus
);
	always_comb begin
		int sh;
		logic hit;
		sh = 0;
		hit = 1'b0;
		if (bus.sec) begin
			sh = sfq_pkg::SEC_SHIFT + ((bus.bp > 3'h3) ? 2 : int'(bus.bp) - 1);
		end else begin
			sh = sfq_pkg::BLK_SHIFT + int'(bus.bp) - 1;
		end
		if (bus.bp == sfq_pkg::BP_NONE) begin
			hit = 1'b0;
		end else if ((!bus.sec && bus.bp == sfq_pkg::BP_ALL) || sh >= AW) begin
			hit = 1'b1;
		end else if (bus.tb) begin
			hit = ((bus.prot_addr >> sh) == '0);
		end else begin
			hit = (((~bus.prot_addr) >> sh) == '0);
		end
		// complement flips the protected region to its remainder
		bus.prot_hit = hit ^ bus.cmp;
	end
endmodule

// File: verif/sfq_flash_props.sv
// port assertions for the multi-lane serial flash core
`timescale 1ns/10ps
module sfq_flash_props #(parameter int PROG_CYCLES = 300) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_quad_enable_bit,
	input logic [3:0] o_serial_io_oe_n,
	input logic o_busy,
	input logic o_write_enable_latch,
	input logic o_wrap_disable_bit,
	input logic [1:0] o_wrap_length_field,
	input logic o_prog_discarded
);
	int busy_cnt_r;
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst)
			busy_cnt_r <= 0;
		else
			busy_cnt_r <= o_busy ? busy_cnt_r + 1 : 0;
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	chk_lanes_idle_off: assert property (
		i_cs_n [*6] |-> o_serial_io_oe_n == 4'hF) else $error("lanes driven with select high");
	chk_busy_after_cs: assert property (
		$rose(o_busy) |-> i_cs_n) else $error("program began inside a frame");
	chk_busy_length: assert property (
		$fell(o_busy) |-> busy_cnt_r == PROG_CYCLES) else $error("program time wrong");
	chk_wel_cleared: assert property (
		$fell(o_busy) |-> !o_write_enable_latch) else $error("latch kept after program");
	chk_prog_needs_wel: assert property (
		$rose(o_busy) |-> o_write_enable_latch) else $error("program without latch");
	chk_busy_status_only: assert property (
		o_busy |-> o_serial_io_oe_n inside {4'hF, 4'hD}) else $error("read served while busy");
	chk_quad_needs_qe: assert property (
		!i_quad_enable_bit |-> o_serial_io_oe_n != 4'h0) else $error("quad drive without enable");
	chk_wrap_held: assert property (
		i_cs_n [*4] |-> $stable({o_wrap_disable_bit, o_wrap_length_field}))
		else $error("wrap setting changed between frames");
	chk_discard_no_prog: assert property (
		$rose(o_prog_discarded) |-> !o_busy [*4]) else $error("discarded program ran");
	cov_program: cover property ($fell(o_busy));
	cov_quad_drive: cover property (o_serial_io_oe_n == 4'h0);
	cov_wrap_read: cover property (!o_wrap_disable_bit && o_serial_io_oe_n == 4'h0);
endmodule
bind sfq_flash sfq_flash_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (.i_clk_sys(i_clk_sys),
	.i_rst(i_rst), .i_cs_n(i_cs_n), .i_quad_enable_bit(i_quad_enable_bit),
	.o_serial_io_oe_n(o_serial_io_oe_n), .o_busy(o_busy),
	.o_write_enable_latch(o_write_enable_latch), .o_wrap_disable_bit(o_wrap_disable_bit),
	.o_wrap_length_field(o_wrap_length_field), .o_prog_discarded(o_prog_discarded));

// File: verif/sfq_host_model.sv
// mode 0 serial host: drives select, serial clock and lanes, samples device lanes
`timescale 1ns/10ps
module sfq_host_model (
	input wire logic i_clk_sys,
	input wire logic [3:0] i_q,
	output logic o_cs_n,
	output logic o_sck,
	output logic [3:0] o_d,
	output logic o_oe_n
);
	initial begin
		o_cs_n = 1'b1;
		o_sck = 1'b0;
		o_d = 4'h0;
		o_oe_n = 1'b1;
	end
	task automatic open();
		@(posedge i_clk_sys);
		o_cs_n <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
	endtask
	// select only rises with the serial clock low, four clocks after its final fall
	task automatic close();
		@(posedge i_clk_sys);
		o_sck <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
		o_cs_n <= 1'b1;
		o_oe_n <= 1'b1;
		repeat (6) @(posedge i_clk_sys);
	endtask
	// lanes change at the fall; device lanes are sampled late in the high phase
	task automatic shift(input int ln, input int n, input bit rel, input logic [31:0] v,
		output logic [31:0] r);
		r = 32'h0;
		// let go of the lanes one clock ahead of the first output fall
		if (rel)
			o_oe_n <= 1'b1;
		for (int k = n - 1; k >= 0; k--) begin
			@(posedge i_clk_sys);
			o_sck <= 1'b0;
			o_oe_n <= rel;
			o_d <= ln == 4 ? v[4*k+:4] : ln == 2 ? {2'h0, v[2*k+:2]} : {3'h0, v[k]};
			repeat (4) @(posedge i_clk_sys);
			o_sck <= 1'b1;
			repeat (3) @(posedge i_clk_sys);
			r = (r << ln) | 32'(ln == 4 ? i_q : ln == 2 ? {2'h0, i_q[1:0]} : {3'h0, i_q[1]});
		end
	endtask
endmodule

// File: verif/sfq_flash_tb_top.sv
// self-checking bench for the multi-lane serial flash core
`timescale 1ns/10ps
module sfq_flash_tb_top;
	localparam int PC = 300;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic qe = 1'b0;
	logic [2:0] bp = 3'h0;
	logic junk = 1'b0;
	logic cmp = 1'b0;
	logic cs_n, sck, h_oe_n, busy, write_enable_latch, wdis, prg_bad;
	logic [3:0] h_d, dq, doe_n, io;
	logic [1:0] wlen;
	logic [7:0] mem [256];
	int n_errors = 0;
	int tests_run = 0;
	always #20 clk = ~clk;
	// released lanes toggle so a stale level cannot pass for data
	always @(posedge clk) junk <= ~junk;
	for (genvar j = 0; j < 4; j++) begin : g_io
		assign io[j] = !doe_n[j] ? dq[j] : (!h_oe_n ? h_d[j] : junk);
	end
	sfq_flash #(.MEM_AW(12), .PROG_CYCLES(PC)) dut (.i_clk_sys(clk), .i_rst(rst), .i_cs_n(cs_n),
		.i_sck(sck), .i_serial_io(io), .o_serial_io(dq), .o_serial_io_oe_n(doe_n),
		.i_quad_enable_bit(qe), .i_protect_complement_bit(cmp),
		.i_sector_granularity_bit(1'b0), .i_top_bottom_bit(1'b0), .i_block_protect_2(bp[2]),
		.i_block_protect_1(bp[1]), .i_block_protect_0(bp[0]), .o_busy(busy),
		.o_write_enable_latch(write_enable_latch), .o_wrap_disable_bit(wdis), .o_wrap_length_field(wlen),
		.o_prog_discarded(prg_bad));
	sfq_host_model host (.i_clk_sys(clk), .i_q(dq), .o_cs_n(cs_n), .o_sck(sck), .o_d(h_d),
		.o_oe_n(h_oe_n));
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wait_idle();
		int k;
		for (k = 0; k < PC + 50 && busy !== 1'b0; k++)
			@(posedge clk);
		if (k >= PC + 50) begin
			n_errors++;
			tally_and_finish();
		end
	endtask
	task automatic op8(input logic [7:0] op);
		logic [31:0] r;
		host.open();
		host.shift(1, 8, 1'b0, 32'(op), r);
		host.close();
	endtask
	task automatic prog(input logic [7:0] a, input int n, input logic [7:0] v0, input int xtra,
		input bit we);
		logic [31:0] r;
		if (we)
			op8(sfq_pkg::OP_WREN);
		host.open();
		host.shift(1, 8, 1'b0, 32'(sfq_pkg::OP_PAGE_PROG), r);
		host.shift(1, 24, 1'b0, {24'h0, a}, r);
		for (int i = 0; i < n; i++)
			host.shift(1, 8, 1'b0, 32'(v0 + i), r);
		if (xtra > 0)
			host.shift(1, xtra, 1'b0, 32'h0, r);
		host.close();
		for (int i = 0; i < n && we && xtra == 0 && bp == 3'h0 && !cmp; i++)
			mem[8'(a + i)] = 8'(v0 + i);
	endtask
	task automatic rd(input logic [7:0] op, input logic [7:0] a, input int n, input int sz,
		input bit on);
		logic [31:0] r;
		int al;
		int dl;
		al = op == sfq_pkg::OP_QUAD_IO ? 4 : op == sfq_pkg::OP_DUAL_IO ? 2 : 1;
		dl = (op == sfq_pkg::OP_DUAL_OUT || op == sfq_pkg::OP_DUAL_IO) ? 2 : 4;
		host.open();
		host.shift(1, 8, 1'b0, 32'(op), r);
		host.shift(al, 24 / al, 1'b0, {24'h0, a}, r);
		if (al > 1)
			host.shift(al, 8 / al, 1'b0, 32'hFF, r);
		if (al != 2)
			host.shift(al, al == 4 ? 4 : 8, 1'b0, 32'h0, r);
		for (int i = 0; i < n; i++) begin
			host.shift(dl, 8 / dl, 1'b1, 32'h0, r);
			check(on ? "read byte" : "refused lanes",
				on ? 32'(mem[8'((a & ~(sz - 1)) | ((a + i) & (sz - 1)))]) : 32'hF,
				on ? r : 32'(doe_n));
		end
		host.close();
	endtask
	task automatic set_wrap(input logic [7:0] w);
		logic [31:0] r;
		host.open();
		host.shift(1, 8, 1'b0, 32'(sfq_pkg::OP_SET_WRAP), r);
		host.shift(4, 6, 1'b0, 32'h0, r);
		host.shift(4, 2, 1'b0, {24'h0, w}, r);
		host.close();
	endtask
	task automatic t_program();
		logic [31:0] s;
		prog(8'h00, 16, 8'hA0, 0, 1'b1);
		host.open();
		host.shift(1, 8, 1'b0, 32'(sfq_pkg::OP_RD_STAT), s);
		host.shift(1, 8, 1'b1, 32'h0, s);
		host.close();
		check("status busy and latch", 32'h3, s & 32'h3);
		wait_idle();
		check("latch after program", 32'h0, 32'(write_enable_latch));
		prog(8'hFE, 3, 8'h5A, 0, 1'b1);
		wait_idle();
		op8(sfq_pkg::OP_WRDI);
		prog(8'h10, 1, 8'h33, 0, 1'b0);
		check("program without latch", 32'h0, 32'({prg_bad, busy}));
		prog(8'h10, 1, 8'h33, 4, 1'b1);
		check("off-boundary program", 32'h2, 32'({prg_bad, busy}));
		bp <= 3'h7;
		prog(8'h10, 1, 8'h33, 0, 1'b1);
		check("protected program", 32'h2, 32'({prg_bad, busy}));
		bp <= 3'h0;
		// complement with no block bits turns the whole array protected
		cmp <= 1'b1;
		prog(8'h10, 1, 8'h33, 0, 1'b1);
		check("complement protect", 32'h2, 32'({prg_bad, busy}));
		cmp <= 1'b0;
		$display("program test done");
	endtask
	task automatic t_reads();
		qe <= 1'b1;
		rd(sfq_pkg::OP_DUAL_OUT, 8'h00, 3, 256, 1'b1);
		rd(sfq_pkg::OP_QUAD_OUT, 8'h0E, 2, 256, 1'b1);
		rd(sfq_pkg::OP_DUAL_IO, 8'hFE, 2, 256, 1'b1);
		rd(sfq_pkg::OP_QUAD_IO, 8'h03, 4, 256, 1'b1);
		qe <= 1'b0;
		rd(sfq_pkg::OP_QUAD_OUT, 8'h00, 1, 256, 1'b0);
		rd(sfq_pkg::OP_QUAD_IO, 8'h00, 1, 256, 1'b0);
		qe <= 1'b1;
		$display("read test done");
	endtask
	task automatic t_wrap();
		for (int l = 3; l >= 0; l--) begin
			set_wrap({1'b1, 2'(l), 1'b0, 4'hF});
			check("wrap fields", 32'(l), 32'({wdis, wlen}));
		end
		rd(sfq_pkg::OP_QUAD_IO, 8'h06, 4, 8, 1'b1);
		rd(sfq_pkg::OP_QUAD_IO, 8'h0E, 3, 8, 1'b1);
		set_wrap(8'h2F);
		rd(sfq_pkg::OP_QUAD_IO, 8'h0E, 3, 16, 1'b1);
		set_wrap(8'h10);
		check("wrap off", 32'h4, 32'({wdis, wlen}));
		rd(sfq_pkg::OP_QUAD_IO, 8'h06, 4, 256, 1'b1);
		$display("wrap test done");
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		check("reset state", 32'h4F, 32'({wdis, write_enable_latch, busy, doe_n}));
		$display("reset test done");
		t_program();
		t_reads();
		t_wrap();
		tally_and_finish();
	end
endmodule
